/* File: common/adc_regs_consts.svh */
// Register offsets, reset values, field positions and frame counts for the register slice.
`ifndef ADC_REGS_CONSTS_SVH
`define ADC_REGS_CONSTS_SVH
`define ADDR_NOISE 15'h002B
`define ADDR_EDGE0 15'h002C
`define ADDR_EDGE1 15'h002D
`define ADDR_EDGE2 15'h002E
`define ADDR_SPAN0 15'h0030
`define ADDR_SPAN1 15'h0031
`define ADDR_PMODE 15'h0037
`define ADDR_TMARK 15'h003B
`define RST_NOISE 8'h10
`define RST_EDGE 24'h000000
`define RST_SPAN 16'hA000
`define RST_PMODE 8'h4B
`define RST_TMARK 8'h00
`define PMODE_LOW 8'h46
`define PMODE_HIGH 8'h4B
`define BIT_ANALOG_QUIET 2
`define BIT_CLOCK_QUIET 0
`define BIT_TM_RECV 0
`define BIT_TM_PECL 1
`define CNT_ADDR_END 5'h10
`define CNT_BYTE_END 5'h18
`define BYTE_ZERO 8'h00
`endif

/* File: common/adc_regs_pkg.sv */
// Types shared by the configuration register slice.
package adc_regs_pkg;
  typedef enum logic {ADDR_PH, DATA_PH} frame_phase_e;
  typedef logic [14:0] reg_addr_t;
endpackage : adc_regs_pkg

/* File: hw/adc_clock_range_power_regs.sv */
// Serial-port register slice: supply quieting, edge position, input span, power mode, time mark.
`timescale 1ns/1ns
`include "adc_regs_consts.svh"
module adc_clock_range_power_regs (
  input wire logic CLOCK, // 125 MHz system clock.
  input wire logic RESET, // Asynchronous reset, active high.
  input wire logic CE, // Clock enable; all state holds while low.
  input wire logic SCS_N, // Serial port chip select, active low, asynchronous pin.
  input wire logic SCLK, // Serial port clock pin, sampled.
  input wire logic SDI, // Serial port data in pin.
  output logic SDO, // Serial port data out.
  output logic SDO_OE_N, // Low while SDO is driven.
  input wire logic EDGE_CAPTURE, // One-cycle strobe: new reference edge captured.
  input wire logic [23:0] EDGE_POSITION, // Edge position measured by the capture logic.
  output logic ANALOG_SUPPLY_QUIETING_ENABLE, // Analog core supply quieting on.
  output logic CLOCK_SUPPLY_QUIETING_ENABLE, // Clock supply quieting on.
  output logic [15:0] INPUT_SPAN_CODE, // Full-scale range code for all channels.
  output logic [7:0] POWER_MODE_CODE, // First power mode code.
  output logic TIME_MARK_RECEIVER_ENABLE, // Time mark input receiver on.
  output logic TIME_MARK_PECL_MODE // Time mark input in PECL mode.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [2:0] sclk_sync_r;
  logic [1:0] cs_sync_r;
  logic [1:0] sdi_sync_r;
  logic [2:0] sclk_sync_nxt;
  logic [1:0] cs_sync_nxt;
  logic [1:0] sdi_sync_nxt;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;

  // Stage one is read only by stage two; the third stage of SCLK feeds the edge detector.
  always_comb begin
    sclk_sync_nxt = {sclk_sync_r[1:0], SCLK};
    cs_sync_nxt = {cs_sync_r[0], SCS_N};
    sdi_sync_nxt = {sdi_sync_r[0], SDI};
  end

  // Idle pin levels at reset keep a half frame from being seen.
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      sclk_sync_r <= 3'h0;
      cs_sync_r <= 2'h3;
      sdi_sync_r <= 2'h0;
    end else if (CE) begin
      sclk_sync_r <= sclk_sync_nxt;
      cs_sync_r <= cs_sync_nxt;
      sdi_sync_r <= sdi_sync_nxt;
    end
  end

  assign cs_active = ~cs_sync_r[1];
  assign sclk_rise = CE & cs_active & sclk_sync_r[1] & ~sclk_sync_r[2];
  assign sclk_fall = CE & cs_active & ~sclk_sync_r[1] & sclk_sync_r[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage and read decode.

  logic [7:0] noise_r;
  logic [23:0] edge_r;
  logic [15:0] span_r;
  logic [7:0] pmode_r;
  logic [7:0] tmark_r;

  // Byte view of the slice; unmapped addresses read as zero.
  function automatic logic [7:0] rd_byte(input adc_regs_pkg::reg_addr_t a);
    unique case (a)
      `ADDR_NOISE: rd_byte = noise_r;
      `ADDR_EDGE0: rd_byte = edge_r[7:0];
      `ADDR_EDGE1: rd_byte = edge_r[15:8];
      `ADDR_EDGE2: rd_byte = edge_r[23:16];
      `ADDR_SPAN0: rd_byte = span_r[7:0];
      `ADDR_SPAN1: rd_byte = span_r[15:8];
      `ADDR_PMODE: rd_byte = pmode_r;
      `ADDR_TMARK: rd_byte = tmark_r;
      default: rd_byte = `BYTE_ZERO;
    endcase
  endfunction : rd_byte

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame engine: read flag, 15-bit address, then data bytes with address ascend.

  adc_regs_pkg::frame_phase_e phase_r, phase_nxt;
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [15:0] in_sr_r, in_sr_nxt;
  logic [7:0] out_sr_r, out_sr_nxt;
  adc_regs_pkg::reg_addr_t addr_r, addr_nxt;
  logic rd_r, rd_nxt;
  logic sdo_nxt;
  logic oe_n_nxt;
  logic wr_go;
  logic [7:0] wr_data;

  assign wr_data = {in_sr_r[6:0], sdi_sync_r[1]};
  assign wr_go = sclk_rise & (phase_r == adc_regs_pkg::DATA_PH) & ~rd_r &
                 (bit_cnt_r == `CNT_BYTE_END - 5'h1);

  // Bits enter on rising SCLK and leave on falling SCLK, MSB first.
  always_comb begin
    phase_nxt = phase_r;
    bit_cnt_nxt = bit_cnt_r;
    in_sr_nxt = in_sr_r;
    out_sr_nxt = out_sr_r;
    addr_nxt = addr_r;
    rd_nxt = rd_r;
    sdo_nxt = SDO;
    oe_n_nxt = 1'b1;
    if (!cs_active) begin
      phase_nxt = adc_regs_pkg::ADDR_PH;
      bit_cnt_nxt = 5'h0;
    end else begin
      oe_n_nxt = ~(rd_r & (phase_r == adc_regs_pkg::DATA_PH));
      if (sclk_rise) begin
        in_sr_nxt = {in_sr_r[14:0], sdi_sync_r[1]};
        bit_cnt_nxt = bit_cnt_r + 5'h1;
        unique case (phase_r)
          adc_regs_pkg::ADDR_PH: begin
            if (bit_cnt_r == `CNT_ADDR_END - 5'h1) begin
              rd_nxt = in_sr_r[14];
              addr_nxt = {in_sr_r[13:0], sdi_sync_r[1]};
              out_sr_nxt = rd_byte({in_sr_r[13:0], sdi_sync_r[1]});
              phase_nxt = adc_regs_pkg::DATA_PH;
            end
          end
          adc_regs_pkg::DATA_PH: begin
            // Streaming: each finished byte moves to the next address.
            if (bit_cnt_r == `CNT_BYTE_END - 5'h1) begin
              bit_cnt_nxt = `CNT_ADDR_END;
              addr_nxt = addr_r + 15'h1;
              out_sr_nxt = rd_byte(addr_r + 15'h1);
            end
          end
        endcase
      end else if (sclk_fall && phase_r == adc_regs_pkg::DATA_PH) begin
        sdo_nxt = out_sr_r[7];
        out_sr_nxt = {out_sr_r[6:0], 1'b0};
      end
    end
  end

  // Frame state; SDO is released one clock after the synchronised chip select reads high.
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      phase_r <= adc_regs_pkg::ADDR_PH;
      bit_cnt_r <= 5'h0;
      in_sr_r <= 16'h0000;
      out_sr_r <= 8'h00;
      addr_r <= 15'h0000;
      rd_r <= 1'b0;
      SDO <= 1'b0;
      SDO_OE_N <= 1'b1;
    end else if (CE) begin
      phase_r <= phase_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      in_sr_r <= in_sr_nxt;
      out_sr_r <= out_sr_nxt;
      addr_r <= addr_nxt;
      rd_r <= rd_nxt;
      SDO <= sdo_nxt;
      SDO_OE_N <= oe_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes and status capture.

  logic [7:0] noise_nxt;
  logic [23:0] edge_nxt;
  logic [15:0] span_nxt;
  logic [7:0] pmode_nxt;
  logic [7:0] tmark_nxt;
  logic pmode_legal;

  assign pmode_legal = (wr_data == `PMODE_LOW) || (wr_data == `PMODE_HIGH);

  // Reserved bits are stored as written so software reads back what it wrote.
  always_comb begin
    noise_nxt = noise_r;
    span_nxt = span_r;
    pmode_nxt = pmode_r;
    tmark_nxt = tmark_r;
    edge_nxt = edge_r;
    if (CE && EDGE_CAPTURE) begin
      edge_nxt = EDGE_POSITION;
    end
    if (wr_go) begin
      unique case (addr_r)
        `ADDR_NOISE: noise_nxt = wr_data;
        `ADDR_SPAN0: span_nxt[7:0] = wr_data;
        `ADDR_SPAN1: span_nxt[15:8] = wr_data;
        // A reserved code is dropped rather than stored, so the core never sees it.
        `ADDR_PMODE: pmode_nxt = pmode_legal ? wr_data : pmode_r;
        `ADDR_TMARK: tmark_nxt = wr_data;
        default: noise_nxt = noise_r;
      endcase
    end
  end

  // Defaults load under reset, before any frame can be taken.
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      noise_r <= `RST_NOISE;
      edge_r <= `RST_EDGE;
      span_r <= `RST_SPAN;
      pmode_r <= `RST_PMODE;
      tmark_r <= `RST_TMARK;
    end else if (CE) begin
      noise_r <= noise_nxt;
      edge_r <= edge_nxt;
      span_r <= span_nxt;
      pmode_r <= pmode_nxt;
      tmark_r <= tmark_nxt;
    end
  end

  // Control outputs are taken straight from the register flops.
  assign ANALOG_SUPPLY_QUIETING_ENABLE = noise_r[`BIT_ANALOG_QUIET];
  assign CLOCK_SUPPLY_QUIETING_ENABLE = noise_r[`BIT_CLOCK_QUIET];
  assign INPUT_SPAN_CODE = span_r;
  assign POWER_MODE_CODE = pmode_r;
  assign TIME_MARK_RECEIVER_ENABLE = tmark_r[`BIT_TM_RECV];
  assign TIME_MARK_PECL_MODE = tmark_r[`BIT_TM_PECL];

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sequence wr_to(adc_regs_pkg::reg_addr_t a);
    wr_go && addr_r == a;
  endsequence

  analog_quiet_a: assert property (wr_to(`ADDR_NOISE) |=>
    ANALOG_SUPPLY_QUIETING_ENABLE == $past(wr_data[`BIT_ANALOG_QUIET]))
    else $error("analog quieting wrong");
  clock_quiet_a: assert property (wr_to(`ADDR_NOISE) |=>
    CLOCK_SUPPLY_QUIETING_ENABLE == $past(wr_data[`BIT_CLOCK_QUIET]))
    else $error("clock quieting wrong");
  edge_capture_a: assert property (CE && EDGE_CAPTURE |=>
    edge_r == $past(EDGE_POSITION)) else $error("edge position not captured");
  edge_hold_a: assert property (!(CE && EDGE_CAPTURE) |=> $stable(edge_r))
    else $error("edge position changed without capture");
  span_high_a: assert property (wr_to(`ADDR_SPAN1) |=>
    INPUT_SPAN_CODE[15:8] == $past(wr_data) && $stable(INPUT_SPAN_CODE[7:0]))
    else $error("span high byte wrong");
  pmode_reject_a: assert property ((wr_to(`ADDR_PMODE) ##0 !pmode_legal) |=>
    $stable(POWER_MODE_CODE)) else $error("reserved power code stored");
  pmode_legal_a: assert property (POWER_MODE_CODE == `PMODE_LOW ||
    POWER_MODE_CODE == `PMODE_HIGH) else $error("power code illegal");
  tmark_mode_a: assert property (wr_to(`ADDR_TMARK) |=>
    TIME_MARK_RECEIVER_ENABLE == $past(wr_data[`BIT_TM_RECV]) &&
    TIME_MARK_PECL_MODE == $past(wr_data[`BIT_TM_PECL]))
    else $error("time mark control wrong");
  reset_load_a: assert property ($past(RESET) |-> INPUT_SPAN_CODE == `RST_SPAN &&
    POWER_MODE_CODE == `RST_PMODE && noise_r == `RST_NOISE) else $error("defaults not loaded");

endmodule : adc_clock_range_power_regs

/* File: tb/adc_clock_range_power_regs_test.sv */
// Self-checking bench for the configuration register slice behind the serial port.
`timescale 1ns/1ns
`include "adc_regs_consts.svh"
module adc_clock_range_power_regs_test;
  ////////////////////////////////////////////////////////////////////////////////
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic scs_n = 1'b1;
  logic sclk = 1'b0;
  logic sdi = 1'b0;
  logic ce = 1'b1;
  logic edge_capture = 1'b0;
  logic [23:0] edge_position = 24'h000000;
  logic sdo, sdo_oe_n, analog_q, clock_q, tm_recv, tm_pecl;
  logic [15:0] span;
  logic [7:0] pmode;
  logic [7:0] v;
  int errors = 0;
  int comparisons = 0;
  // Rows hold address, byte written and byte expected back; bad codes and status stay put.
  // Quieting writes keep the reserved bits at default and the span stays at or above 0x2000.
  // The power rows stand for whole mode changes made with calibration and link already off;
  // the companion mode registers, recalibration and those enables sit outside this slice.
  logic [30:0] rows [9] = '{{`ADDR_NOISE, 8'h15, 8'h15},
    {`ADDR_SPAN0, 8'h55, 8'h55}, {`ADDR_SPAN1, 8'h20, 8'h20},
    {`ADDR_PMODE, 8'h46, 8'h46}, {`ADDR_PMODE, 8'h13, 8'h46},
    {`ADDR_PMODE, 8'h4B, 8'h4B}, {`ADDR_TMARK, 8'h03, 8'h03}, {`ADDR_EDGE0, 8'hFF, 8'h00},
    {15'h0040, 8'hAA, 8'h00}};

  // The clock enable is driven by the bench so that the freeze path is exercised too.
  adc_clock_range_power_regs i_adc_clock_range_power_regs (
    .CLOCK(clock), .RESET(reset), .CE(ce), .SCS_N(scs_n), .SCLK(sclk), .SDI(sdi),
    .SDO(sdo), .SDO_OE_N(sdo_oe_n), .EDGE_CAPTURE(edge_capture), .EDGE_POSITION(edge_position),
    .ANALOG_SUPPLY_QUIETING_ENABLE(analog_q), .CLOCK_SUPPLY_QUIETING_ENABLE(clock_q),
    .INPUT_SPAN_CODE(span), .POWER_MODE_CODE(pmode), .TIME_MARK_RECEIVER_ENABLE(tm_recv),
    .TIME_MARK_PECL_MODE(tm_pecl));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 125 MHz clock.
  initial forever #4 clock = ~clock;

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One single-byte frame; half periods of six clocks leave room for the pin synchroniser.
  task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                       output logic [7:0] rdat);
    logic [23:0] word;
    word = {rd, addr, wd};
    rdat = 8'h00;
    @(posedge clock);
    scs_n <= 1'b0;
    repeat (3) @(posedge clock);
    for (int i = 23; i >= 0; i--) begin
      sclk <= 1'b0;
      sdi <= word[i];
      repeat (6) @(posedge clock);
      sclk <= 1'b1;
      if (i < 8) rdat[i] = sdo;
      if (rd && i == 7) chk("sdo_oe_n in data", 24'(sdo_oe_n), 24'h0);
      repeat (6) @(posedge clock);
    end
    sclk <= 1'b0;
    repeat (6) @(posedge clock);
    scs_n <= 1'b1;
    repeat (5) @(posedge clock);
    chk("sdo_oe_n idle", 24'(sdo_oe_n), 24'h1);
  endtask : frame

  task automatic rd_chk(input string what, input logic [14:0] addr, input logic [7:0] exp);
    logic [7:0] r;
    frame(1'b1, addr, 8'h00, r);
    chk(what, 24'(r), 24'(exp));
  endtask : rd_chk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the roughly forty frames of about 300 clocks each.
  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    end_sim();
  end

  // Main sequence: table loop first, then the hand-written cases.
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    for (int r = 0; r < 9; r++) begin
      frame(1'b0, rows[r][30:16], rows[r][15:8], v);
      rd_chk("row readback", rows[r][30:16], rows[r][7:0]);
    end
    chk("span code", 24'(span), 24'h002055);
    chk("power code", 24'(pmode), 24'h00004B);
    $display("test table done");
    // All four patterns of the two quieting bits, with the two time mark bits set to the same pattern.
    for (int b = 0; b < 4; b++) begin
      frame(1'b0, `ADDR_NOISE, 8'h10 | {5'h00, b[1], 1'b0, b[0]}, v);
      frame(1'b0, `ADDR_TMARK, {6'h00, b[1:0]}, v);
      chk("analog quiet", 24'(analog_q), 24'(b[1]));
      chk("clock quiet", 24'(clock_q), 24'(b[0]));
      chk("tm receiver", 24'(tm_recv), 24'(b[0]));
      chk("tm pecl", 24'(tm_pecl), 24'(b[1]));
    end
    $display("test control bits done");
    // Capture strobe loads the position; a new position without a strobe is not taken.
    @(posedge clock);
    edge_position <= 24'h3C5A96;
    edge_capture <= 1'b1;
    @(posedge clock);
    edge_capture <= 1'b0;
    edge_position <= 24'h123456;
    frame(1'b0, `ADDR_EDGE1, 8'h00, v);
    rd_chk("edge byte 0", `ADDR_EDGE0, 8'h96);
    rd_chk("edge byte 1", `ADDR_EDGE1, 8'h5A);
    rd_chk("edge byte 2", `ADDR_EDGE2, 8'h3C);
    $display("test edge status done");
    // A capture strobe while the clock enable is low must be lost, as all state holds.
    @(posedge clock);
    ce <= 1'b0;
    edge_position <= 24'h777777;
    edge_capture <= 1'b1;
    @(posedge clock);
    edge_capture <= 1'b0;
    ce <= 1'b1;
    rd_chk("edge frozen", `ADDR_EDGE0, 8'h96);
    $display("test clock enable done");
    // Reset in mid-run returns every output and register to its default.
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    chk("span reset", 24'(span), 24'h00A000);
    chk("power reset", 24'(pmode), 24'h00004B);
    chk("ctrl reset", 24'({analog_q, clock_q, tm_recv, tm_pecl}), 24'h0);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    rd_chk("noise reset", `ADDR_NOISE, `RST_NOISE);
    rd_chk("edge reset", `ADDR_EDGE0, 8'h00);
    rd_chk("span lo reset", `ADDR_SPAN0, 8'h00);
    rd_chk("span hi reset", `ADDR_SPAN1, 8'hA0);
    rd_chk("power reset rd", `ADDR_PMODE, `RST_PMODE);
    rd_chk("tmark reset", `ADDR_TMARK, `RST_TMARK);
    $display("test reset done");
    end_sim();
  end
endmodule : adc_clock_range_power_regs_test
